// file: rtl/dual_capture.sv
`timescale 1ns/1ps
// Dual-channel triggered capture front end. Samples arrive from the
// converter pins with a strobe, are scaled per channel, and are written
// into a circular record memory per channel. Software reads the finished
// record through a registered read port, indexed from the record start.
module dual_capture
   import capture_pkg::*;
#(
   parameter int SAMPLE_W = 16,
   parameter int SENS_W = 16,
   parameter int ADDR_W = 15
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic adc_strobe,
   input wire logic [SAMPLE_W-1:0] adc_chan_one,
   input wire logic [SAMPLE_W-1:0] adc_chan_two,
   input wire logic meas_start,
   input wire logic analyzer_reset,
   input wire logic chan_one_enable,
   input wire logic chan_two_enable,
   input wire logic [SENS_W-1:0] chan_one_sens,
   input wire logic [SENS_W-1:0] chan_two_sens,
   input wire logic [1:0] trig_source,
   input wire logic trig_edge_mode,
   input wire logic trig_negative,
   input wire logic [SAMPLE_W-1:0] trig_level,
   input wire logic [31:0] trig_delay,
   input wire logic [capture_pkg::BLOCK_W-1:0] block_len,
   input wire logic [capture_pkg::BLOCK_W-1:0] rd_addr,
   output logic [SAMPLE_W+SENS_W-1:0] chan_one_time_record,
   output logic [SAMPLE_W+SENS_W-1:0] chan_two_time_record,
   output logic output_active,
   output logic capture_busy,
   output logic capture_done,
   output logic triggered,
   output logic cfg_error
);
   import capture_pkg::*;

   localparam int PROD_W = SAMPLE_W + SENS_W;
   localparam int DEPTH = 1 << ADDR_W;

   // The memory must hold the longest single-channel block.
   if (ADDR_W < BLOCK_W) begin : g_addr_check
      $error("ADDR_W too small for the longest block");
   end

   // Two-flop synchronisers for the strobe and both sample buses.
   logic strobe_meta;
   logic strobe_sync;
   logic strobe_last;
   logic [SAMPLE_W-1:0] one_meta;
   logic [SAMPLE_W-1:0] one_sync;
   logic [SAMPLE_W-1:0] two_meta;
   logic [SAMPLE_W-1:0] two_sync;
   logic sample_event;

   // Scaled stream from the two channel instances.
   logic one_valid;
   logic two_valid;
   logic signed [SAMPLE_W-1:0] one_raw;
   logic signed [SAMPLE_W-1:0] two_raw;
   logic signed [PROD_W-1:0] one_scaled;
   logic signed [PROD_W-1:0] two_scaled;
   logic s_valid;

   // Sequencer state and pointers.
   cap_state_t state;
   logic [ADDR_W-1:0] wr_ptr;
   logic [ADDR_W-1:0] rec_base;
   logic [BLOCK_W-1:0] fill_cnt;
   logic [BLOCK_W-1:0] left_cnt;
   logic [31:0] wait_cnt;

   // Trigger evaluation signals.
   logic signed [SAMPLE_W-1:0] trig_cur;
   logic signed [SAMPLE_W-1:0] trig_prev;
   logic prev_valid;
   logic trig_hit;
   logic [BLOCK_W-1:0] pre_len;
   logic [BLOCK_W-1:0] post_len;
   logic wr_en;

   // Record memories, one per channel; no reset, contents are data only.
   logic [PROD_W-1:0] mem_one [0:DEPTH-1];
   logic [PROD_W-1:0] mem_two [0:DEPTH-1];

   // Synchroniser chain; the first stages feed only the second stages.
   always_ff @(posedge clk) begin
      if (reset) begin
         strobe_meta <= 1'b0;
         strobe_sync <= 1'b0;
         strobe_last <= 1'b0;
      end else begin
         strobe_meta <= adc_strobe;
         strobe_sync <= strobe_meta;
         strobe_last <= strobe_sync;
      end
   end

   // Sample buses travel beside the strobe, so they are settled when it rises.
   always_ff @(posedge clk) begin
      one_meta <= adc_chan_one;
      one_sync <= one_meta;
      two_meta <= adc_chan_two;
      two_sync <= two_meta;
   end

   // One strobe edge takes both channels at the same instant.
   assign sample_event = strobe_sync & ~strobe_last;

   // Channel one scaling.
   channel_scaler #(
      .SAMPLE_W(SAMPLE_W),
      .SENS_W(SENS_W)
   ) u_scale_one (
      .clk(clk),
      .reset(reset),
      .in_valid(sample_event),
      .sample(one_sync),
      .sens(chan_one_sens),
      .out_valid(one_valid),
      .out_raw(one_raw),
      .out_scaled(one_scaled)
   );

   // Channel two scaling, fed by the same event.
   channel_scaler #(
      .SAMPLE_W(SAMPLE_W),
      .SENS_W(SENS_W)
   ) u_scale_two (
      .clk(clk),
      .reset(reset),
      .in_valid(sample_event),
      .sample(two_sync),
      .sens(chan_two_sens),
      .out_valid(two_valid),
      .out_raw(two_raw),
      .out_scaled(two_scaled)
   );

   // Both valids are identical; combining them keeps each one read.
   assign s_valid = one_valid & two_valid;

   // Pick the trigger channel; with the source off the value is unused.
   always_comb begin
      unique case (trig_source)
         SRC_CHAN_TWO: trig_cur = two_raw;
         default: trig_cur = one_raw;
      endcase
   end

   // Samples and threshold share the full-range scale, so no conversion
   // is needed; +1.0 saturates to the largest positive code.
   always_comb begin
      trig_hit = 1'b0;
      if (!trig_edge_mode) begin
         // Level mode looks only at the current sample.
         if (trig_negative) begin
            trig_hit = trig_cur < $signed(trig_level);
         end else begin
            trig_hit = trig_cur > $signed(trig_level);
         end
      end else if (prev_valid) begin
         // Edge mode: a crossing also fixes the sign of cur - prev.
         if (trig_negative) begin
            trig_hit = (trig_cur < $signed(trig_level))
                     && (trig_prev > $signed(trig_level));
         end else begin
            trig_hit = (trig_cur > $signed(trig_level))
                     && (trig_prev < $signed(trig_level));
         end
      end
   end

   // Previous sample on the trigger channel, one per sample while armed.
   always_ff @(posedge clk) begin
      if (reset || state != ST_ARM) begin
         prev_valid <= 1'b0;
         trig_prev <= '0;
      end else if (s_valid) begin
         trig_prev <= trig_cur;
         prev_valid <= 1'b1;
      end
   end

   // Pre-trigger length from a negative delay, clipped at the block size.
   always_comb begin
      pre_len = '0;
      if (trig_delay[31]) begin
         if ((~trig_delay + 32'h0000_0001) > {17'h00000, block_len}) begin
            pre_len = block_len;
         end else begin
            pre_len = BLOCK_W'(~trig_delay + 32'h0000_0001);
         end
      end
   end

   // Samples to take from the trigger sample on, that sample included.
   assign post_len = block_len - pre_len;

   // Memory is written while armed (history) and while recording.
   assign wr_en = s_valid && (state == ST_ARM || state == ST_RECORD
                  || (state == ST_WAIT && wait_cnt == 32'h0000_0001));

   // Capture sequencer; the analyzer reset drops any capture at once.
   always_ff @(posedge clk) begin
      if (reset || analyzer_reset) begin
         state <= ST_IDLE;
         fill_cnt <= '0;
         left_cnt <= '0;
         wait_cnt <= '0;
         rec_base <= '0;
         triggered <= 1'b0;
         capture_done <= 1'b0;
         capture_busy <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE, ST_DONE: begin
               if (meas_start) begin
                  fill_cnt <= '0;
                  triggered <= 1'b0;
                  capture_done <= 1'b0;
                  capture_busy <= 1'b1;
                  if (trig_source == SRC_OFF) begin
                     // Free run: start now, the delay is not looked at.
                     state <= ST_RECORD;
                     left_cnt <= block_len;
                     rec_base <= wr_ptr;
                  end else begin
                     state <= ST_ARM;
                  end
               end
            end
            ST_ARM: begin
               if (s_valid) begin
                  if (fill_cnt != block_len) begin
                     fill_cnt <= fill_cnt + 15'h0001;
                  end
                  // A trigger counts only once enough history is held.
                  if (trig_hit && fill_cnt >= pre_len) begin
                     triggered <= 1'b1;
                     if (!trig_delay[31] && trig_delay != 32'h0000_0000) begin
                        state <= ST_WAIT;
                        wait_cnt <= trig_delay;
                     end else begin
                        rec_base <= wr_ptr - ADDR_W'(pre_len);
                        if (post_len <= 15'h0001) begin
                           state <= ST_DONE;
                           capture_done <= 1'b1;
                           capture_busy <= 1'b0;
                        end else begin
                           state <= ST_RECORD;
                           left_cnt <= post_len - 15'h0001;
                        end
                     end
                  end
               end
            end
            ST_WAIT: begin
               if (s_valid) begin
                  if (wait_cnt == 32'h0000_0001) begin
                     // This sample is the first one of the record.
                     rec_base <= wr_ptr;
                     state <= ST_RECORD;
                     left_cnt <= block_len - 15'h0001;
                  end else begin
                     wait_cnt <= wait_cnt - 32'h0000_0001;
                  end
               end
            end
            ST_RECORD: begin
               if (s_valid) begin
                  if (left_cnt <= 15'h0001) begin
                     state <= ST_DONE;
                     capture_done <= 1'b1;
                     capture_busy <= 1'b0;
                  end else begin
                     left_cnt <= left_cnt - 15'h0001;
                  end
               end
            end
            default: begin
               // An illegal code returns to idle.
               state <= ST_IDLE;
               capture_busy <= 1'b0;
            end
         endcase
      end
   end

   // Write pointer runs freely round the power-of-two memory.
   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr <= '0;
      end else if (wr_en) begin
         wr_ptr <= wr_ptr + ADDR_W'(1);
      end
   end

   // Each enabled channel writes on the same sample under one trigger.
   always_ff @(posedge clk) begin
      if (wr_en && chan_one_enable) begin
         mem_one[wr_ptr] <= one_scaled;
      end
      if (wr_en && chan_two_enable) begin
         mem_two[wr_ptr] <= two_scaled;
      end
   end

   // Registered read, relative to the record start.
   always_ff @(posedge clk) begin
      if (reset) begin
         chan_one_time_record <= '0;
         chan_two_time_record <= '0;
      end else begin
         chan_one_time_record <= mem_one[rec_base + ADDR_W'(rd_addr)];
         chan_two_time_record <= mem_two[rec_base + ADDR_W'(rd_addr)];
      end
   end

   // Source output runs from start until a reset, through pauses and done.
   always_ff @(posedge clk) begin
      if (reset || analyzer_reset) begin
         output_active <= 1'b0;
      end else if (meas_start) begin
         output_active <= 1'b1;
      end
   end

   // Flags a block length outside the legal window; capture still runs,
   // since keeping it legal is software's job.
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_error <= 1'b0;
      end else if (chan_one_enable && chan_two_enable) begin
         cfg_error <= (block_len <= BLOCK_MIN) || (block_len >= BLOCK_MAX_DUAL);
      end else begin
         cfg_error <= (block_len <= BLOCK_MIN) || (block_len >= BLOCK_MAX_SINGLE);
      end
   end
endmodule

// file: rtl/capture_pkg.sv
// Functional notes
// - With a trigger source, keep storing history while armed.
// - Trigger source is channel one, two or off.
// - Trigger type is edge or level.
// - Threshold is signed full-range fraction, compared directly.
// - Direction is sign of current minus previous.
// - Edge fires on crossing in chosen direction.
// - Level fires on current sample versus threshold.
// - Delay is signed, minus block size to 32767.
// - Pre-trigger up to block, post up to 2^31.
// - Negative delay pre-triggers, positive delay post-triggers.
// - Free run ignores the programmed delay.
// - Stored value is sample times channel sensitivity.
// - Both channels sampled on the same instants.
// - One trigger starts both channels together.
// - Output runs from measurement start until reset.
// - Analyzer reset halts output and capture.
package capture_pkg;
   // Width of a block length or a record read address.
   localparam int BLOCK_W = 15;
   // Smallest block length is one more than this value.
   localparam logic [BLOCK_W-1:0] BLOCK_MIN = 15'h0002;
   // Block length must stay below these limits.
   localparam logic [BLOCK_W-1:0] BLOCK_MAX_SINGLE = 15'h5000;
   localparam logic [BLOCK_W-1:0] BLOCK_MAX_DUAL = 15'h2800;
   // Largest positive trigger delay that software may program.
   localparam logic [31:0] DELAY_MAX = 32'h0000_7fff;
   // Trigger source codes.
   localparam logic [1:0] SRC_OFF = 2'h0;
   localparam logic [1:0] SRC_CHAN_ONE = 2'h1;
   localparam logic [1:0] SRC_CHAN_TWO = 2'h2;
   // Capture sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ARM = 3'b001,
      ST_WAIT = 3'b010,
      ST_RECORD = 3'b011,
      ST_DONE = 3'b100
   } cap_state_t;
endpackage

// file: rtl/channel_scaler.sv
`timescale 1ns/1ps
// One channel of the front end: registers the raw sample and its
// engineering_unit product in the same cycle, so that both channels leave
// aligned when they are fed by the same strobe.
module channel_scaler #(
   parameter int SAMPLE_W = 16,
   parameter int SENS_W = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   input wire logic signed [SAMPLE_W-1:0] sample,
   input wire logic signed [SENS_W-1:0] sens,
   output logic out_valid,
   output logic signed [SAMPLE_W-1:0] out_raw,
   output logic signed [SAMPLE_W+SENS_W-1:0] out_scaled
);
   // The valid flag is control state and therefore takes a reset value.
   always_ff @(posedge clk) begin
      if (reset) begin
         out_valid <= 1'b0;
      end else begin
         out_valid <= in_valid;
      end
   end

   // Data registers load only with a sample; the full-width product loses no bits.
   always_ff @(posedge clk) begin
      if (in_valid) begin
         out_raw <= sample;
         out_scaled <= sample * sens;
      end
   end
endmodule

// file: bench/dual_capture_props.sv
`timescale 1ns/1ps
// Watches the capture front end from its own ports only.
module dual_capture_props
   import capture_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic meas_start,
   input wire logic analyzer_reset,
   input wire logic chan_one_enable,
   input wire logic chan_two_enable,
   input wire logic [1:0] trig_source,
   input wire logic [capture_pkg::BLOCK_W-1:0] block_len,
   input wire logic output_active,
   input wire logic capture_busy,
   input wire logic capture_done,
   input wire logic triggered,
   input wire logic cfg_error
);
   import capture_pkg::*;

   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // A start request that the sequencer is free to accept.
   sequence s_start;
      meas_start && !capture_busy && !analyzer_reset;
   endsequence
   // A capture in progress never shows a stale done flag.
   sequence s_running;
      capture_busy && !capture_done;
   endsequence
   AST_START_BUSY: assert property (s_start |=> s_running)
      else $error("capture did not start");
   AST_OUT_START: assert property (meas_start && !analyzer_reset |=> output_active)
      else $error("output did not start");
   AST_OUT_HOLD: assert property (output_active && !analyzer_reset |=> output_active)
      else $error("output stopped without reset");
   AST_HALT: assert property (analyzer_reset |=> !output_active && !capture_busy)
      else $error("analyzer reset did not halt");
   AST_TRIG_FIRST: assert property (
      $rose(capture_done) && trig_source != SRC_OFF |-> triggered)
      else $error("record finished without trigger");
   AST_TRIG_HOLD: assert property (
      triggered && capture_busy && !analyzer_reset |=> triggered)
      else $error("trigger flag lost mid capture");
   AST_DONE_HOLD: assert property (
      capture_done && !meas_start && !analyzer_reset |=> capture_done)
      else $error("done flag dropped");
   AST_CFG_SMALL: assert property (
      $stable(block_len) && block_len <= BLOCK_MIN |=> cfg_error)
      else $error("short block not flagged");
   AST_CFG_DUAL: assert property ($stable({chan_one_enable, chan_two_enable, block_len})
      && chan_one_enable && chan_two_enable && block_len >= BLOCK_MAX_DUAL |=> cfg_error)
      else $error("long dual block not flagged");
endmodule
bind dual_capture dual_capture_props u_props(.clk(clk), .reset(reset), .meas_start(meas_start),
   .analyzer_reset(analyzer_reset), .chan_one_enable(chan_one_enable),
   .chan_two_enable(chan_two_enable), .trig_source(trig_source), .block_len(block_len),
   .output_active(output_active), .capture_busy(capture_busy), .capture_done(capture_done),
   .triggered(triggered), .cfg_error(cfg_error));

// file: bench/adc_model.sv
`timescale 1ns/1ps
// Converter model: one strobe per sample pair, data held around the rise.
module adc_model (
   input wire logic clk,
   output logic adc_strobe,
   output logic [15:0] adc_chan_one,
   output logic [15:0] adc_chan_two
);
   initial begin
      adc_strobe = 1'b0;
      adc_chan_one = 16'h0000;
      adc_chan_two = 16'h0000;
   end
   // Both lanes change together under one strobe.
   task send(input logic [15:0] s1, input logic [15:0] s2);
      @(negedge clk);
      adc_chan_one = s1;
      adc_chan_two = s2;
      repeat (2) @(negedge clk);
      adc_strobe = 1'b1;
      repeat (4) @(negedge clk);
      adc_strobe = 1'b0;
      // Hold time over, so the lanes stop showing the old word.
      adc_chan_one = ~s1;
      adc_chan_two = ~s2;
      repeat (2) @(negedge clk);
   endtask
endmodule

// file: bench/dual_capture_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module dual_capture_tb;
   import capture_pkg::*;
   logic clk, reset, adc_strobe, meas_start, analyzer_reset;
   logic chan_one_enable, chan_two_enable, trig_edge_mode, trig_negative;
   logic [15:0] adc_chan_one, adc_chan_two, chan_one_sens, chan_two_sens, trig_level;
   logic [1:0] trig_source;
   logic [31:0] trig_delay, chan_one_time_record, chan_two_time_record;
   logic [BLOCK_W-1:0] block_len, rd_addr;
   logic output_active, capture_busy, capture_done, triggered, cfg_error;
   int n_mismatch, check_count;
   // Sample pairs fed by the next scenario.
   logic [15:0] a[8], b[8];
   dual_capture u_dual_capture(.clk(clk), .reset(reset), .adc_strobe(adc_strobe),
      .adc_chan_one(adc_chan_one), .adc_chan_two(adc_chan_two), .meas_start(meas_start),
      .analyzer_reset(analyzer_reset), .chan_one_enable(chan_one_enable),
      .chan_two_enable(chan_two_enable), .chan_one_sens(chan_one_sens),
      .chan_two_sens(chan_two_sens), .trig_source(trig_source), .trig_edge_mode(trig_edge_mode),
      .trig_negative(trig_negative), .trig_level(trig_level), .trig_delay(trig_delay),
      .block_len(block_len), .rd_addr(rd_addr), .chan_one_time_record(chan_one_time_record),
      .chan_two_time_record(chan_two_time_record), .output_active(output_active),
      .capture_busy(capture_busy), .capture_done(capture_done), .triggered(triggered),
      .cfg_error(cfg_error));
   adc_model u_adc_model(.clk(clk), .adc_strobe(adc_strobe), .adc_chan_one(adc_chan_one),
      .adc_chan_two(adc_chan_two));
   // Free running clock, 50 ns period.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Expected engineering_unit value, signed product.
   function automatic logic [31:0] sc(input logic [15:0] s, input logic [15:0] k);
      logic signed [31:0] r;
      r = $signed(s) * $signed(k);
      return r;
   endfunction
   // Verdict and end of run.
   task results;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // One measurement: configure, start, feed cnt pairs, wait, read four words.
   task scen(input logic [1:0] src, input logic e, input logic n, input logic [15:0] lv,
      input logic [31:0] d, input int cnt, input int off, input int tix, input logic t);
      int i;
      @(negedge clk);
      trig_source = src;
      trig_edge_mode = e;
      trig_negative = n;
      trig_level = lv;
      trig_delay = d;
      meas_start = 1'b1;
      @(negedge clk);
      meas_start = 1'b0;
      `CHK("busy", 1'b1, capture_busy)
      for (i = 0; i < cnt; i++) begin
         if (i == tix) `CHK("early trigger", 1'b0, triggered)
         u_adc_model.send(a[i], b[i]);
      end
      // Bounded wait; the record should close within a few cycles.
      for (i = 0; i < 40 && capture_done !== 1'b1; i++) @(negedge clk);
      `CHK("done", 1'b1, capture_done)
      `CHK("triggered", t, triggered)
      `CHK("output", 1'b1, output_active)
      for (i = 0; i < 4; i++) begin
         rd_addr = i[BLOCK_W-1:0];
         repeat (2) @(negedge clk);
         `CHK("chan one word", sc(a[off+i], chan_one_sens), chan_one_time_record)
         `CHK("chan two word", sc(b[off+i], chan_two_sens), chan_two_time_record)
      end
   endtask
   // Block length limits for one or two channels.
   task cfgchk(input logic [BLOCK_W-1:0] len, input logic en2, input logic ex);
      @(negedge clk);
      block_len = len;
      chan_two_enable = en2;
      repeat (3) @(negedge clk);
      `CHK("cfg error", ex, cfg_error)
   endtask
   // Hang guard, far beyond the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      results;
   end
   initial begin
      reset = 1'b1;
      meas_start = 1'b0;
      analyzer_reset = 1'b0;
      chan_one_enable = 1'b1;
      chan_two_enable = 1'b1;
      chan_one_sens = 16'h0002;
      chan_two_sens = 16'hfffd;
      trig_source = SRC_OFF;
      trig_edge_mode = 1'b0;
      trig_negative = 1'b0;
      trig_level = 16'h0000;
      trig_delay = 32'h0000_0000;
      block_len = 15'h0004;
      rd_addr = 15'h0000;
      n_mismatch = 0;
      check_count = 0;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      `CHK("output after reset", 1'b0, output_active)
      a = '{16'h0010, 16'h0020, 16'h0030, 16'h0040, 0, 0, 0, 0};
      b = '{16'h0001, 16'h0002, 16'hffff, 16'h8000, 0, 0, 0, 0};
      scen(SRC_OFF, 1'b0, 1'b0, 16'h7fff, 32'h0000_0005, 4, 0, 99, 1'b0);
      a = '{16'h0050, 16'h0080, 16'h0200, 16'h0300, 16'h0400, 16'h0500, 0, 0};
      b = '{16'h0007, 16'h0006, 16'h0005, 16'h0004, 16'h0003, 16'h0002, 0, 0};
      scen(SRC_CHAN_ONE, 1'b1, 1'b0, 16'h0100, 32'h0, 6, 2, 2, 1'b1);
      a = '{16'h0300, 16'h0200, 16'h0050, 16'h0040, 0, 0, 0, 0};
      scen(SRC_CHAN_ONE, 1'b1, 1'b1, 16'h0100, 32'hffff_fffe, 4, 0, 2, 1'b1);
      a = '{16'h0011, 16'h0012, 16'h0013, 16'h0014, 16'h0015, 16'h0016, 0, 0};
      b = '{16'h0005, 16'h0003, 16'hffff, 16'hfffe, 16'hfffd, 16'hfffc, 0, 0};
      scen(SRC_CHAN_TWO, 1'b0, 1'b1, 16'h0000, 32'h0, 6, 2, 2, 1'b1);
      a = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 0, 0};
      scen(SRC_CHAN_ONE, 1'b0, 1'b0, 16'h0000, 32'h0000_0002, 6, 2, 0, 1'b1);
      cfgchk(15'h0002, 1'b1, 1'b1);
      cfgchk(15'h2800, 1'b1, 1'b1);
      cfgchk(15'h27ff, 1'b1, 1'b0);
      cfgchk(15'h5000, 1'b0, 1'b1);
      cfgchk(15'h0004, 1'b1, 1'b0);
      // A level never exceeded keeps the capture waiting until halted.
      scen_halt();
      results;
   end
   task scen_halt;
      @(negedge clk);
      trig_source = SRC_CHAN_ONE;
      trig_edge_mode = 1'b0;
      trig_negative = 1'b0;
      trig_level = 16'h7fff;
      meas_start = 1'b1;
      @(negedge clk);
      meas_start = 1'b0;
      u_adc_model.send(16'h0100, 16'h0100);
      `CHK("waiting", 1'b1, capture_busy)
      analyzer_reset = 1'b1;
      @(negedge clk);
      analyzer_reset = 1'b0;
      `CHK("busy halted", 1'b0, capture_busy)
      `CHK("output halted", 1'b0, output_active)
   endtask
endmodule
